// ---- include/gpp_cfg_if.sv ----
// Interface carrying the register contents from the register file.
`timescale 1ns/1ps
interface gpp_cfg_if #(
    parameter int WIDTH = 8
);
    logic [WIDTH-1:0] port_output_latch;    // Stored output values.
    logic [WIDTH-1:0] port_direction;       // One means output.
    logic [WIDTH-1:0] port_pullup_enable;   // Pull-up requests.
    logic [WIDTH-1:0] port_function_select; // One means wake input.

    // Register file drives the settings.
    modport regs (
        output port_output_latch,
        output port_direction,
        output port_pullup_enable,
        output port_function_select
    );

    // Pin logic consumes them.
    modport pins (
        input port_output_latch,
        input port_direction,
        input port_pullup_enable,
        input port_function_select
    );
endinterface

// ---- include/gpp_pkg.sv ----
// Package with register map, reset values and modes of the eight-pin port.
package gpp_pkg;

    // ------------------------------------------------------------------
    // Register offsets on the plain register port.
    // ------------------------------------------------------------------
    localparam logic [7:0] GPP_OFF_MODE   = 8'hCC; // Function select.
    localparam logic [7:0] GPP_OFF_LATCH  = 8'hD8; // Output latch.
    localparam logic [7:0] GPP_OFF_PULLUP = 8'hE2; // Pull-up enable.
    localparam logic [7:0] GPP_OFF_DIR    = 8'hE8; // Direction.

    // ------------------------------------------------------------------
    // Reset values and fixed read values.
    // ------------------------------------------------------------------
    localparam logic [7:0] GPP_RST_LATCH  = 8'h00; // Latch after reset.
    localparam logic [7:0] GPP_RST_DIR    = 8'h00; // All inputs.
    localparam logic [7:0] GPP_RST_PULLUP = 8'h00; // All pull-ups off.
    localparam logic [7:0] GPP_RST_MODE   = 8'h00; // All general I/O.
    localparam logic [7:0] GPP_DIR_READ   = 8'hFF; // Direction reads ones.
    localparam logic [7:0] GPP_UNMAPPED   = 8'h00; // Unmapped read value.

    // ------------------------------------------------------------------
    // Operating modes of the device as seen by the pins.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        GPP_MODE_ACTIVE,
        GPP_MODE_SUBACTIVE,
        GPP_MODE_SLEEP,
        GPP_MODE_SUBSLEEP,
        GPP_MODE_STANDBY,
        GPP_MODE_WATCH
    } gpp_power_mode_t;

endpackage

// ---- logic/gpp_port.sv ----
// Top of the eight-pin port: registers, pin drivers and power modes.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - eight-bit read/write output latch
// - output pins read back latch value
// - input pins read back live level
// - direction bit one output, zero input
// - direction is write-only, reads all ones
// - latch clears to zero on reset
// - direction clears to inputs on reset
// - pull-up only when input and enabled; sleep, subsleep and watch hold the last pull-up state
// - pull-up enable read/write, reset zero
// - mode bit one selects wake input
// - wake function forces pin to input in run modes; standby drives it high when its pull-up is on
// - mode register read/write, reset zero
// - standby floats pins, pull-up pins high
module gpp_port
    import gpp_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic            clock_in,
    input  wire logic            reset_in,
    input  wire logic [7:0]      addr_in,
    input  wire logic [WIDTH-1:0] wdata_in,
    input  wire logic            wr_in,
    input  wire logic            rd_in,
    output logic     [WIDTH-1:0] rdata_out,
    input  wire gpp_power_mode_t power_mode_in,
    input  wire logic [WIDTH-1:0] general_io_pin_in,
    output logic     [WIDTH-1:0] general_io_pin_out,
    output logic     [WIDTH-1:0] general_io_pin_oe_out,
    output logic     [WIDTH-1:0] pullup_on_out,
    output logic     [WIDTH-1:0] wake_input_pin_out
);

    // ------------------------------------------------------------------
    // Register file.
    // ------------------------------------------------------------------
    gpp_cfg_if #(.WIDTH(WIDTH)) cfg (); // Settings from the registers.

    gpp_regs #(.WIDTH(WIDTH)) u_regs (
        .clock_in     (clock_in),
        .reset_in     (reset_in),
        .addr_in      (addr_in),
        .wdata_in     (wdata_in),
        .wr_in        (wr_in),
        .rd_in        (rd_in),
        .pin_level_in (general_io_pin_in),
        .rdata_out    (rdata_out),
        .cfg          (cfg.regs)
    );

    // ------------------------------------------------------------------
    // Pin state registers.
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] pin_q;    // Driven level.
    logic [WIDTH-1:0] oe_q;     // Output enable.
    logic [WIDTH-1:0] pu_q;     // Pull-up on.
    logic [WIDTH-1:0] wake_q;   // Wake input level.
    logic [WIDTH-1:0] pin_d;    // Next driven level.
    logic [WIDTH-1:0] oe_d;     // Next output enable.
    logic [WIDTH-1:0] pu_d;     // Next pull-up state.
    logic [WIDTH-1:0] wake_d;   // Next wake input level.

    // Power mode classes.
    wire mode_run     = (power_mode_in == GPP_MODE_ACTIVE) ||
                        (power_mode_in == GPP_MODE_SUBACTIVE);
    wire mode_standby = (power_mode_in == GPP_MODE_STANDBY);

    // Per-pin drive and pull-up in run modes, in standby, and held in the other modes; wake follows the pin in every mode.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            wire drive_out = cfg.port_direction[i] &
                             ~cfg.port_function_select[i];
            wire pull_on = cfg.port_pullup_enable[i] &
                           ~cfg.port_direction[i];
            assign oe_d[i]  = mode_run ? drive_out :
                              mode_standby ? pull_on : oe_q[i];
            assign pin_d[i] = mode_run ? cfg.port_output_latch[i] :
                              mode_standby ? 1'b1 : pin_q[i];
            assign pu_d[i]  = (mode_run | mode_standby) ? pull_on : pu_q[i];
            // wake input sees the pin when selected
            assign wake_d[i] = cfg.port_function_select[i] &
                               general_io_pin_in[i];
        end
    endgenerate

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pin_q  <= '0;
            oe_q   <= '0;
            pu_q   <= '0;
            wake_q <= '0;
        end else begin
            pin_q  <= pin_d;
            oe_q   <= oe_d;
            pu_q   <= pu_d;
            wake_q <= wake_d;
        end
    end

    assign general_io_pin_out    = pin_q;
    assign general_io_pin_oe_out = oe_q;
    assign pullup_on_out         = pu_q;
    assign wake_input_pin_out    = wake_q;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    AST_WAKE_IS_INPUT: assert property (
        @(posedge clock_in) disable iff (reset_in)
        mode_run && |cfg.port_function_select |=>
            (oe_q & $past(cfg.port_function_select)) == '0)
        else $error("wake pin driven as output");

    AST_PULLUP_OFF_OUT: assert property (
        @(posedge clock_in) disable iff (reset_in)
        mode_run |=> (pu_q & $past(cfg.port_direction)) == '0)
        else $error("pull-up on for output pin");

    AST_RUN_DRIVE: assert property (
        @(posedge clock_in) disable iff (reset_in)
        mode_run |=> oe_q == $past(cfg.port_direction &
                                   ~cfg.port_function_select))
        else $error("output enable does not follow direction");

    AST_STANDBY_FLOAT: assert property (
        @(posedge clock_in) disable iff (reset_in)
        mode_standby |=> oe_q == $past(cfg.port_pullup_enable &
                                       ~cfg.port_direction)
                         && (pin_q & oe_q) == oe_q)
        else $error("standby pin state wrong");

    AST_SLEEP_HOLD: assert property (
        @(posedge clock_in) disable iff (reset_in)
        !mode_run && !mode_standby |=> $stable(oe_q) && $stable(pin_q))
        else $error("pin state not held in sleep");

    AST_RESET_FLOAT: assert property (
        @(posedge clock_in) reset_in |=> oe_q == '0)
        else $error("pins driven after reset");

endmodule

// ---- logic/gpp_regs.sv ----
// Register file of the eight-pin port with its plain register port.
`timescale 1ns/1ps
module gpp_regs
    import gpp_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clock_in,
    input  wire logic             reset_in,
    input  wire logic [7:0]       addr_in,
    input  wire logic [WIDTH-1:0] wdata_in,
    input  wire logic             wr_in,
    input  wire logic             rd_in,
    input  wire logic [WIDTH-1:0] pin_level_in,
    output logic      [WIDTH-1:0] rdata_out,
    gpp_cfg_if.regs               cfg
);

    // ------------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] latch_q;  // Output latch.
    logic [WIDTH-1:0] dir_q;    // Direction.
    logic [WIDTH-1:0] pullup_q; // Pull-up enables.
    logic [WIDTH-1:0] mode_q;   // Function select.
    logic [WIDTH-1:0] rdata_q;  // Read data, valid one cycle after strobe.
    logic [WIDTH-1:0] rdata_d;  // Next read data.
    logic [WIDTH-1:0] latch_view; // Latch read mix of stored and live.

    // ------------------------------------------------------------------
    // Address decode.
    // ------------------------------------------------------------------
    wire sel_latch  = (addr_in == GPP_OFF_LATCH);  // Latch selected.
    wire sel_dir    = (addr_in == GPP_OFF_DIR);    // Direction selected.
    wire sel_pullup = (addr_in == GPP_OFF_PULLUP); // Pull-up selected.
    wire sel_mode   = (addr_in == GPP_OFF_MODE);   // Mode selected.

    assign latch_view = (latch_q & dir_q) | (pin_level_in & ~dir_q);

    assign rdata_d = sel_latch  ? latch_view :
                     sel_dir    ? WIDTH'(GPP_DIR_READ) :
                     sel_pullup ? pullup_q :
                     sel_mode   ? mode_q : WIDTH'(GPP_UNMAPPED);

    // Register writes; reset values.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            latch_q  <= WIDTH'(GPP_RST_LATCH);
            dir_q    <= WIDTH'(GPP_RST_DIR);
            pullup_q <= WIDTH'(GPP_RST_PULLUP);
            mode_q   <= WIDTH'(GPP_RST_MODE);
        end else if (wr_in) begin
            if (sel_latch) latch_q <= wdata_in;
            if (sel_dir) dir_q <= wdata_in;
            if (sel_pullup) pullup_q <= wdata_in;
            if (sel_mode) mode_q <= wdata_in;
        end
    end

    // Read data register; holds data only in the cycle after a read.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rd_in ? rdata_d : '0;
        end
    end

    assign rdata_out                = rdata_q;
    assign cfg.port_output_latch    = latch_q;
    assign cfg.port_direction       = dir_q;
    assign cfg.port_pullup_enable   = pullup_q;
    assign cfg.port_function_select = mode_q;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    AST_DIR_READ_ONES: assert property (
        @(posedge clock_in) disable iff (reset_in)
        rd_in && sel_dir |=> rdata_out == {WIDTH{1'b1}})
        else $error("direction read did not return all ones");

    AST_LATCH_READ: assert property (
        @(posedge clock_in) disable iff (reset_in)
        rd_in && sel_latch |=>
            ((rdata_out & $past(dir_q)) == ($past(latch_q) & $past(dir_q))))
        else $error("output pin read did not return latch");

    AST_PIN_READ: assert property (
        @(posedge clock_in) disable iff (reset_in)
        rd_in && sel_latch |=>
            ((rdata_out & ~$past(dir_q)) ==
             ($past(pin_level_in) & ~$past(dir_q))))
        else $error("input pin read did not return pin level");

    AST_LATCH_WRITE: assert property (
        @(posedge clock_in) disable iff (reset_in)
        wr_in && sel_latch |=> latch_q == $past(wdata_in))
        else $error("latch write not stored");

    AST_RESET_CLEAR: assert property (
        @(posedge clock_in)
        reset_in |=> latch_q == '0 && dir_q == '0 && pullup_q == '0
                     && mode_q == '0)
        else $error("registers not cleared by reset");

endmodule

// ---- sim/gpp_board_model.sv ----
// Board model that drives, pulls up or floats the eight port pins.
`timescale 1ns/1ps
module gpp_board_model (
    input  wire logic       clock_in,
    input  wire logic [7:0] oe_in,
    input  wire logic [7:0] drive_in,
    input  wire logic [7:0] pullup_in,
    input  wire logic [7:0] ext_en_in,
    input  wire logic [7:0] ext_val_in,
    output logic      [7:0] level_out
);
    logic [7:0] float_q = 8'h5A; // Changing pattern on undriven pins.

    // Undriven pins toggle every cycle so a stale level never passes.
    always @(posedge clock_in) begin
        float_q <= ~float_q;
    end

    // pull-up level
    // Port drive wins, then the board, then the pull-up, else floating.
    assign level_out = (oe_in & drive_in)
        | (~oe_in & ext_en_in & ext_val_in)
        | (~oe_in & ~ext_en_in & pullup_in)
        | (~oe_in & ~ext_en_in & ~pullup_in & float_q);
endmodule

// ---- sim/tb_eight_bit_port_with_pullup_wake.sv ----
// Self-checking bench of the eight-pin port with random traffic.
`timescale 1ns/1ps
module tb_eight_bit_port_with_pullup_wake
    import gpp_pkg::*;
;
    logic            clock_in = 1'b0;  // System clock.
    logic            reset_in = 1'b1;  // Synchronous reset.
    logic [7:0]      addr_in  = 8'h00; // Register address.
    logic [7:0]      wdata_in = 8'h00; // Write data.
    logic            wr_in    = 1'b0;  // Write strobe.
    logic            rd_in    = 1'b0;  // Read strobe.
    gpp_power_mode_t power_mode_in = GPP_MODE_ACTIVE; // Power mode.
    logic [7:0]      rdata_out, pin_level, pin_out, pin_oe, pu_on, wake;
    logic [7:0]      ext_en_q = 8'hFF; // Board drives these pins.
    logic [7:0]      ext_val_q = 8'h00; // Board drive levels.
    logic [7:0]      lat, dir, pul, mod; // Shadow registers.
    logic [31:0]     seed = 32'h0404D48B; // Random state.
    int              miscompares = 0;
    int              tests_run = 0;

    always #5 clock_in = ~clock_in;

    gpp_port u_dut (.clock_in(clock_in), .reset_in(reset_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out),
        .power_mode_in(power_mode_in), .general_io_pin_in(pin_level),
        .general_io_pin_out(pin_out), .general_io_pin_oe_out(pin_oe),
        .pullup_on_out(pu_on), .wake_input_pin_out(wake));

    gpp_board_model u_board (.clock_in(clock_in), .oe_in(pin_oe),
        .drive_in(pin_out), .pullup_in(pu_on), .ext_en_in(ext_en_q),
        .ext_val_in(ext_val_q), .level_out(pin_level));

    // Prints counts and verdict, then stops the run.
    task automatic end_of_test();
        $display("Counts: run=%0d mismatches=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Compares one byte and reports a mismatch at once.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Next random byte from the xorshift state.
    function automatic logic [7:0] nx();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    // One-cycle write on the register port.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask

    // One-cycle read; data stands only in the following cycle.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, exp);
        @(posedge clock_in);
        #1 chk(rdata_out, 8'h00);
    endtask

    // Expected level on every pin from the board and the settings.
    function automatic logic [7:0] lv();
        logic [7:0] oe;
        oe = dir & ~mod;
        return (oe & lat) | (~oe & ((ext_en_q & ext_val_q)
            | (~ext_en_q & pul & ~dir)));
    endfunction

    // Loads all four registers; the board covers every floating pin.
    task automatic apply(input logic [7:0] l, d, p, m, v, r);
        lat = l;
        dir = d;
        pul = p;
        mod = m;
        ext_val_q <= v;
        ext_en_q <= r | ~(p & ~d);
        wr(GPP_OFF_LATCH, l);
        wr(GPP_OFF_DIR, d);
        wr(GPP_OFF_PULLUP, p);
        wr(GPP_OFF_MODE, m);
        repeat (2) @(posedge clock_in);
        #1;
    endtask

    // Checks the pin outputs in a functional power mode.
    task automatic check_pins();
        chk(pin_oe, dir & ~mod);
        chk(pin_out, lat);
        chk(pu_on, pul & ~dir);
        chk(wake, lv() & mod);
    endtask

    // Reads back every register and one unmapped place.
    task automatic check_regs();
        rd(GPP_OFF_LATCH, (lat & dir) | (lv() & ~dir));
        rd(GPP_OFF_PULLUP, pul);
        rd(GPP_OFF_MODE, mod);
        rd(GPP_OFF_DIR, GPP_DIR_READ);
        wr(8'hD9, 8'hFF);
        rd(8'hD9, GPP_UNMAPPED);
        rd(GPP_OFF_LATCH, (lat & dir) | (lv() & ~dir));
    endtask

    // Holds reset for n edges, checks floating pins, then checks defaults.
    task automatic do_reset(input int n);
        logic [7:0] v;
        v = nx();
        reset_in <= 1'b1;
        ext_en_q <= 8'hFF;
        ext_val_q <= v;
        repeat (n - 1) @(posedge clock_in);
        #1 chk(pin_oe, 8'h00);
        chk(pu_on, 8'h00);
        @(posedge clock_in);
        reset_in <= 1'b0;
        lat = GPP_RST_LATCH;
        dir = GPP_RST_DIR;
        pul = GPP_RST_PULLUP;
        mod = GPP_RST_MODE;
        repeat (2) @(posedge clock_in);
        #1 check_pins();
        check_regs();
        wr(GPP_OFF_DIR, 8'hFF);
        dir = 8'hFF;
        rd(GPP_OFF_LATCH, 8'h00);
        $display("test reset done");
    endtask

    // Main sequence: corners, random traffic, power modes, second reset.
    initial begin
        logic [7:0] b [6];
        logic [7:0] s_oe, s_out, s_pu;
        do_reset(4);
        apply(8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00);
        check_pins();
        check_regs();
        apply(8'hA5, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h0F);
        check_pins();
        check_regs();
        $display("test corners done");
        for (int i = 0; i < 40; i++) begin
            foreach (b[j]) b[j] = nx();
            apply(b[0], b[1], b[2], b[3], b[4], b[5]);
            check_pins();
            check_regs();
        end
        $display("test random done");
        for (int k = 0; k < 6; k++) begin
            foreach (b[j]) b[j] = nx();
            apply(b[0], b[1], b[2], b[3], b[4], 8'hFF);
            s_oe = dir & ~mod;
            s_out = lat;
            s_pu = pul & ~dir;
            power_mode_in <= gpp_power_mode_t'(k);
            apply(~b[0], ~b[1], ~b[2], b[3] ^ 8'h3C, b[4], 8'hFF);
            if (k < 2) begin
                check_pins();
            end else if (k == 4) begin
                chk(pin_oe, pul & ~dir);
                chk(pin_out & pin_oe, pin_oe);
                chk(pu_on, pul & ~dir);
            end else begin
                chk(pin_oe, s_oe);
                chk(pin_out, s_out);
                chk(pu_on, s_pu);
            end
            power_mode_in <= GPP_MODE_ACTIVE;
        end
        $display("test power modes done");
        do_reset(2);
        end_of_test();
    end

    // Watchdog at about fourteen times the expected run length.
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
endmodule
